// File: logic/ld_cfg.svh
/*
 constants for the serial flash boot loader: register offsets, field positions,
 reset values, flash addresses and clock timing.
 assumes inclusion by bare name from the loader sources.
*/
`ifndef LD_CFG_SVH
`define LD_CFG_SVH

// register offsets (byte addresses on the plain register port)
`define LD_OFF_CTRL 8'h00
`define LD_OFF_CMD 8'h04
`define LD_OFF_STATUS 8'h08
`define LD_OFF_UTX 8'h0c
`define LD_OFF_URX 8'h10

// control fields
`define LD_CTRL_DUAL 0
`define LD_CTRL_GOLD_EXT 1
`define LD_CTRL_PORT_LO 2
`define LD_CTRL_PORT_HI 3
`define LD_CTRL_USER_CS 4
`define LD_CTRL_USER_EN 5
`define LD_CTRL_W 6
`define LD_CTRL_RST 6'h04
`define LD_CMD_RELOAD 0

// master port setting encodings
`define LD_PORT_DISABLE 2'h0
`define LD_PORT_ENABLE 2'h1
`define LD_PORT_USER_RSV 2'h2

// flash protocol
`define LD_READ_OP 8'h03
`define LD_SINGLE_BASE 24'h000000
`define LD_DUAL_BASE 24'h010000
`define LD_CRC_INIT 16'hffff
`define LD_CRC_POLY 16'h1021

// timing: half periods of the master clock in reference cycles
`define LD_REF_KHZ 250000
`define LD_NOM_KHZ 2080
`define LD_NOM_HALF 8'(`LD_REF_KHZ / (2 * `LD_NOM_KHZ))
`define LD_HALF_MIN 8'h02

// synchroniser reset levels: {program_request_n, master_serial_in, scan[3:0]}
`define LD_SYNC_W 6
`define LD_SYNC_RST 6'h20

`endif

// File: logic/ld_pkg.sv
/*
 types shared by the serial flash boot loader modules.
 assumes nothing beyond a SystemVerilog compiler.
*/
package ld_pkg;

	typedef enum {
		LD_IDLE, LD_ARB, LD_SDM, LD_CMD, LD_PRE, LD_RATE, LD_ROW, LD_CRC, LD_WR,
		LD_DWAIT, LD_FALL, LD_USER, LD_FAIL
	} ld_state_t;

	typedef struct packed {
		logic clk;
		logic sel_n;
		logic mosi;
	} ld_pins_t;

	typedef struct packed {
		logic en;
		logic sclk;
		logic sel_n;
		logic mosi;
	} ld_scan_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ld_bus_t;

endpackage

// File: logic/ld_shift.sv
/*
 one byte serial shifter, clock polarity and phase mode 0, msb first.
 assumes miso_i is already synchronised and half_i stays stable during a byte.
*/
`timescale 1ns/1ps
`default_nettype none

module ld_shift import ld_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// byte request
	input wire logic start_i,
	input wire logic [7:0] tx_i,
	input wire logic [7:0] half_i,
	// serial side
	input wire logic miso_i,
	output logic sclk_o,
	output logic mosi_o,
	// result
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rx_o
);

	logic [7:0] cnt_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_q <= 8'h00;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			sclk_o <= 1'b0;
			mosi_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			rx_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				// first bit stands before the first rising edge
				busy_o <= 1'b1;
				sh_q <= tx_i;
				mosi_o <= tx_i[7];
				cnt_q <= 8'h00;
				bit_q <= 3'h0;
				sclk_o <= 1'b0;
			end else if (busy_o) begin
				if (cnt_q == half_i - 8'h01) begin
					cnt_q <= 8'h00;
					if (!sclk_o) begin
						sclk_o <= 1'b1;
						rx_o <= {rx_o[6:0], miso_i};
					end else begin
						sclk_o <= 1'b0;
						if (bit_q == 3'h7) begin
							busy_o <= 1'b0;
							done_o <= 1'b1;
						end else begin
							bit_q <= bit_q + 3'h1;
							sh_q <= {sh_q[6:0], 1'b0};
							mosi_o <= sh_q[6];
						end
					end
				end else begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: logic/ld_boot_loader.sv
/*
 serial flash boot loader: fetches the configuration bitstream over the master
 serial port, checks each row, falls back to the golden image, then hands the
 pins to the user controller or the scan pass-through.
 assumes a single 250 MHz clock, internal self-download and configuration memory
 on the same clock, and a flash that answers the plain read opcode.
// Summary of operation
// - start a load at power-up, on a reload command, or program request release
// - every load starts with the master clock at nominal 2.08 MHz
// - during a load hold select low, shift commands out, capture flash data
// - after all data is fetched, raise select and float the serial outputs
// - only the 03 hex read opcode is sent; flash must accept it
// - skip padding, read the rate field, fetch the rest at the new rate
// - no preamble within the allowed time fails the attempt
// - single-image external mode reads from flash address zero
// - dual-image mode reads the external image from 0x010000
// - in user mode the serial port pins are released
// - dual-image: primary first, golden fallback only after primary fails
// - bad row CRC erases configuration memory and reloads from golden
// - master clock pulse count expiring before done falls back to golden
// - golden location option reverses primary and fallback order
// - user reservation setting keeps the pins for user logic, no dual boot
// - erased feature row keeps the master serial port inactive
// - user mode controller drives the pins through control and data registers
// - scan pass-through lets an outside host reach the flash
*/
`timescale 1ns/1ps
`default_nettype none
`include "ld_cfg.svh"

module ld_boot_loader import ld_pkg::*; #(
	parameter int ROW_BYTES = 16,
	parameter int ROWS = 4,
	parameter int PRE_LIMIT = 64,
	parameter int TIMEOUT_PULSES = 100000,
	parameter logic [15:0] PREAMBLE = 16'ha5c3
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// register port
	input wire ld_bus_t bus_i,
	output logic [31:0] rdata_o,
	// flash pins
	output ld_pins_t flash_o,
	output ld_pins_t flash_oe_o,
	input wire logic master_serial_in_i,
	input wire logic program_request_n_i,
	// scan pass-through
	input wire ld_scan_t scan_i,
	output logic scan_miso_o,
	// internal image loader and configuration memory
	input wire logic feature_row_erased_i,
	output logic sdm_start_o,
	input wire logic sdm_done_i,
	input wire logic sdm_fail_i,
	output logic [7:0] cfg_data_o,
	output logic cfg_wr_o,
	output logic cfg_row_end_o,
	output logic cfg_erase_o,
	input wire logic cfg_done_i,
	// status
	output logic user_mode_o,
	output logic load_fail_o
);

	localparam int IW = (ROW_BYTES > 1) ? $clog2(ROW_BYTES) : 1;
	localparam logic [15:0] RB = 16'(ROW_BYTES);
	localparam logic [15:0] NROWS = 16'(ROWS);
	localparam logic [15:0] PLIM = 16'(PRE_LIMIT);
	localparam logic [31:0] TOUT = 32'(TIMEOUT_PULSES);

	ld_state_t st_q;
	logic [`LD_CTRL_W-1:0] ctrl_q;
	logic [7:0] utx_q;
	logic attempt_q, src_ext_q, dual_run_q, por_pend_q, prog_prev_q;
	logic [23:0] base_q;
	logic [15:0] byte_q, row_q, pre_cnt_q, win_q, crc_q, crc_rx_q;
	logic [7:0] half_q, eng_tx_q;
	logic eng_start_q, sdm_start_q, cfg_wr_q, cfg_row_end_q, cfg_erase_q, load_fail_q;
	logic [7:0] cfg_data_q;
	logic user_mode_q, failed_q;
	logic [31:0] pulse_q;
	logic [8:0] mc_cnt_q;
	logic [7:0] rowbuf_q [ROW_BYTES];
	ld_pins_t pin_q, oe_q, pin_d, oe_d;
	logic [31:0] rdata_q;
	logic [`LD_SYNC_W-1:0] clean;
	logic eng_sclk, eng_mosi, eng_busy, eng_done;
	logic [7:0] eng_rx;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ `LD_CRC_POLY) : {r[14:0], 1'b0};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once the second and third stages agree

	logic [`LD_SYNC_W-1:0] raw;
	assign raw = {program_request_n_i, master_serial_in_i, scan_i};

	for (genvar gi = 0; gi < `LD_SYNC_W; gi++) begin : g_sync
		logic s1_q, s2_q, s3_q, c_q;
		localparam logic [`LD_SYNC_W-1:0] RSTV = `LD_SYNC_RST;
		always_ff @(posedge ref_clk_i) begin
			if (!resetn_i) begin
				s1_q <= RSTV[gi];
				s2_q <= RSTV[gi];
				s3_q <= RSTV[gi];
				c_q <= RSTV[gi];
			end else begin
				s1_q <= raw[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					c_q <= s3_q;
				end
			end
		end
		assign clean[gi] = c_q;
	end

	logic prog_s, miso_s;
	ld_scan_t scan_s;
	assign prog_s = clean[5];
	assign miso_s = clean[4];
	assign scan_s = clean[3:0];

	////////////////////////////////////////////////////////////////////////////
	// register port

	logic reload_wr, utx_wr, loading, attempting, port_ok, eng_idle, eng_issue;
	assign reload_wr = bus_i.wr && bus_i.addr == `LD_OFF_CMD && bus_i.wdata[`LD_CMD_RELOAD];
	assign utx_wr = bus_i.wr && bus_i.addr == `LD_OFF_UTX;

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			ctrl_q <= `LD_CTRL_RST;
			utx_q <= 8'h00;
		end else begin
			if (bus_i.wr && bus_i.addr == `LD_OFF_CTRL) begin
				ctrl_q <= bus_i.wdata[`LD_CTRL_W-1:0];
			end
			if (utx_wr) begin
				utx_q <= bus_i.wdata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			if (bus_i.rd) begin
				case (bus_i.addr)
					`LD_OFF_CTRL: rdata_q <= {26'h0, ctrl_q};
					`LD_OFF_STATUS: rdata_q <= {16'h0, half_q, 2'h0, eng_busy, src_ext_q,
						attempt_q, loading, failed_q, user_mode_q};
					`LD_OFF_URX: rdata_q <= {24'h0, eng_rx};
					default: rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// byte shifter shared by the loader and the user controller

	assign loading = st_q inside {LD_CMD, LD_PRE, LD_RATE, LD_ROW, LD_CRC, LD_WR};
	assign attempting = loading || st_q inside {LD_SDM, LD_DWAIT};
	assign port_ok = !feature_row_erased_i && ctrl_q[`LD_CTRL_PORT_HI:`LD_CTRL_PORT_LO] == `LD_PORT_ENABLE;
	assign eng_idle = !eng_busy && !eng_start_q && !eng_done;
	assign eng_issue = eng_idle && (st_q inside {LD_CMD, LD_PRE, LD_RATE, LD_ROW}
		|| (st_q == LD_USER && utx_wr && ctrl_q[`LD_CTRL_USER_EN]));

	ld_shift u_shift (
		.clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.start_i(eng_start_q),
		.tx_i(eng_tx_q),
		.half_i(half_q),
		.miso_i(miso_s),
		.sclk_o(eng_sclk),
		.mosi_o(eng_mosi),
		.busy_o(eng_busy),
		.done_o(eng_done),
		.rx_o(eng_rx)
	);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			eng_start_q <= 1'b0;
			eng_tx_q <= 8'h00;
		end else begin
			eng_start_q <= eng_issue;
			if (eng_issue) begin
				case (st_q)
					LD_CMD: eng_tx_q <= (byte_q == 16'h0) ? `LD_READ_OP :
						(byte_q == 16'h1) ? base_q[23:16] :
						(byte_q == 16'h2) ? base_q[15:8] : base_q[7:0];
					LD_USER: eng_tx_q <= bus_i.wdata[7:0];
					default: eng_tx_q <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// master clock pulse counter for the load timeout

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			mc_cnt_q <= 9'h000;
			pulse_q <= 32'h0;
		end else if (!attempting) begin
			mc_cnt_q <= 9'h000;
			pulse_q <= 32'h0;
		end else if (mc_cnt_q >= {half_q, 1'b0} - 9'h001) begin
			mc_cnt_q <= 9'h000;
			pulse_q <= pulse_q + 32'h1;
		end else begin
			mc_cnt_q <= mc_cnt_q + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// row buffer: a row waits here until its CRC has been checked

	always_ff @(posedge ref_clk_i) begin
		if (st_q == LD_ROW && eng_done && byte_q < RB) begin
			rowbuf_q[byte_q[IW-1:0]] <= eng_rx;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// load sequencer

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			st_q <= LD_IDLE;
			por_pend_q <= 1'b1;
			prog_prev_q <= 1'b1;
			attempt_q <= 1'b0;
			src_ext_q <= 1'b0;
			dual_run_q <= 1'b0;
			base_q <= `LD_SINGLE_BASE;
			byte_q <= 16'h0;
			row_q <= 16'h0;
			pre_cnt_q <= 16'h0;
			win_q <= 16'h0;
			crc_q <= `LD_CRC_INIT;
			crc_rx_q <= 16'h0;
			half_q <= `LD_NOM_HALF;
			sdm_start_q <= 1'b0;
			cfg_data_q <= 8'h00;
			cfg_wr_q <= 1'b0;
			cfg_row_end_q <= 1'b0;
			cfg_erase_q <= 1'b0;
			load_fail_q <= 1'b0;
			user_mode_q <= 1'b0;
			failed_q <= 1'b0;
		end else begin
			prog_prev_q <= prog_s;
			sdm_start_q <= 1'b0;
			cfg_wr_q <= 1'b0;
			cfg_row_end_q <= 1'b0;
			cfg_erase_q <= 1'b0;
			load_fail_q <= 1'b0;
			case (st_q)
				LD_IDLE, LD_USER, LD_FAIL: begin
					if (prog_s && (por_pend_q || reload_wr || !prog_prev_q)) begin
						st_q <= LD_ARB;
						por_pend_q <= 1'b0;
						user_mode_q <= 1'b0;
						failed_q <= 1'b0;
					end
				end
				LD_ARB: begin
					half_q <= `LD_NOM_HALF;
					attempt_q <= 1'b0;
					byte_q <= 16'h0;
					dual_run_q <= port_ok && ctrl_q[`LD_CTRL_DUAL];
					base_q <= ctrl_q[`LD_CTRL_DUAL] ? `LD_DUAL_BASE : `LD_SINGLE_BASE;
					if (eng_busy || eng_start_q) begin
						// a byte cut off by a program request must end before a new frame
						st_q <= LD_ARB;
					end else if (!port_ok) begin
						// port inactive: only the internal image can be tried
						src_ext_q <= 1'b0;
						attempt_q <= 1'b1;
						sdm_start_q <= 1'b1;
						st_q <= LD_SDM;
					end else if (ctrl_q[`LD_CTRL_DUAL] && ctrl_q[`LD_CTRL_GOLD_EXT]) begin
						src_ext_q <= 1'b0;
						sdm_start_q <= 1'b1;
						st_q <= LD_SDM;
					end else begin
						src_ext_q <= 1'b1;
						st_q <= LD_CMD;
					end
				end
				LD_SDM: begin
					if (sdm_done_i) begin
						st_q <= LD_USER;
						user_mode_q <= 1'b1;
					end else if (sdm_fail_i) begin
						st_q <= LD_FALL;
					end
				end
				LD_CMD: begin
					if (eng_done) begin
						byte_q <= byte_q + 16'h1;
						if (byte_q == 16'h3) begin
							st_q <= LD_PRE;
							pre_cnt_q <= 16'h0;
							win_q <= 16'h0;
						end
					end
				end
				LD_PRE: begin
					if (eng_done) begin
						// padding is skipped by sliding until the preamble appears
						win_q <= {win_q[7:0], eng_rx};
						pre_cnt_q <= pre_cnt_q + 16'h1;
						if ({win_q[7:0], eng_rx} == PREAMBLE) begin
							st_q <= LD_RATE;
						end else if (pre_cnt_q + 16'h1 >= PLIM) begin
							st_q <= LD_FALL;
						end
					end
				end
				LD_RATE: begin
					if (eng_done) begin
						half_q <= (eng_rx < `LD_HALF_MIN) ? `LD_HALF_MIN : eng_rx;
						st_q <= LD_ROW;
						byte_q <= 16'h0;
						row_q <= 16'h0;
						crc_q <= `LD_CRC_INIT;
					end
				end
				LD_ROW: begin
					if (eng_done) begin
						byte_q <= byte_q + 16'h1;
						if (byte_q < RB) begin
							crc_q <= crc_byte(crc_q, eng_rx);
						end else if (byte_q == RB) begin
							crc_rx_q[15:8] <= eng_rx;
						end else begin
							crc_rx_q[7:0] <= eng_rx;
							st_q <= LD_CRC;
						end
					end
				end
				LD_CRC: begin
					byte_q <= 16'h0;
					st_q <= (crc_rx_q == crc_q) ? LD_WR : LD_FALL;
				end
				LD_WR: begin
					cfg_data_q <= rowbuf_q[byte_q[IW-1:0]];
					cfg_wr_q <= 1'b1;
					byte_q <= byte_q + 16'h1;
					if (byte_q == RB - 16'h1) begin
						cfg_row_end_q <= 1'b1;
						byte_q <= 16'h0;
						crc_q <= `LD_CRC_INIT;
						row_q <= row_q + 16'h1;
						st_q <= (row_q == NROWS - 16'h1) ? LD_DWAIT : LD_ROW;
					end
				end
				LD_DWAIT: begin
					if (cfg_done_i) begin
						st_q <= LD_USER;
						user_mode_q <= 1'b1;
					end
				end
				LD_FALL: begin
					// a timed-out byte still clocks; its late done must not count as a command
					if (!eng_busy && !eng_start_q) begin
						cfg_erase_q <= 1'b1;
						half_q <= `LD_NOM_HALF;
						byte_q <= 16'h0;
						if (!attempt_q && dual_run_q) begin
							attempt_q <= 1'b1;
							src_ext_q <= !src_ext_q;
							sdm_start_q <= src_ext_q;
							st_q <= src_ext_q ? LD_SDM : LD_CMD;
						end else begin
							st_q <= LD_FAIL;
							load_fail_q <= 1'b1;
							failed_q <= 1'b1;
						end
					end
				end
				default: st_q <= LD_IDLE;
			endcase
			if (attempting && pulse_q >= TOUT) begin
				st_q <= LD_FALL;
			end
			if (!prog_s) begin
				// a held program request parks the loader until it is released
				st_q <= LD_IDLE;
				user_mode_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin ownership: loader, then scan pass-through, then user controller

	always_comb begin
		pin_d = '{clk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
		oe_d = '{clk: 1'b0, sel_n: 1'b0, mosi: 1'b0};
		if (loading) begin
			pin_d = '{clk: eng_sclk, sel_n: 1'b0, mosi: eng_mosi};
			oe_d = '{clk: 1'b1, sel_n: 1'b1, mosi: 1'b1};
		end else if (scan_s.en && st_q != LD_SDM) begin
			pin_d = '{clk: scan_s.sclk, sel_n: scan_s.sel_n, mosi: scan_s.mosi};
			oe_d = '{clk: 1'b1, sel_n: 1'b1, mosi: 1'b1};
		end else if (st_q == LD_USER && ctrl_q[`LD_CTRL_USER_EN]) begin
			pin_d = '{clk: eng_sclk, sel_n: !ctrl_q[`LD_CTRL_USER_CS], mosi: eng_mosi};
			oe_d = '{clk: 1'b1, sel_n: 1'b1, mosi: 1'b1};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			pin_q <= '{clk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
			oe_q <= '{clk: 1'b0, sel_n: 1'b0, mosi: 1'b0};
			scan_miso_o <= 1'b0;
		end else begin
			pin_q <= pin_d;
			oe_q <= oe_d;
			scan_miso_o <= miso_s;
		end
	end

	assign flash_o = pin_q;
	assign flash_oe_o = oe_q;
	assign rdata_o = rdata_q;
	assign sdm_start_o = sdm_start_q;
	assign cfg_data_o = cfg_data_q;
	assign cfg_wr_o = cfg_wr_q;
	assign cfg_row_end_o = cfg_row_end_q;
	assign cfg_erase_o = cfg_erase_q;
	assign user_mode_o = user_mode_q;
	assign load_fail_o = load_fail_q;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	a_select_low_load: assert property (st_q == LD_CMD |=> pin_q.sel_n == 1'b0 && oe_q.sel_n)
		else $error("select not low while loading");
	a_read_opcode: assert property ($rose(st_q == LD_CMD) |=> eng_start_q && eng_tx_q == `LD_READ_OP)
		else $error("first byte is not the read opcode");
	a_nominal_rate: assert property (st_q == LD_ARB |=> half_q == `LD_NOM_HALF)
		else $error("load did not start at nominal rate");
	a_release_pins: assert property (st_q == LD_DWAIT && !scan_s.en |=> oe_q == 3'b000)
		else $error("pins driven after data fetched");
	a_crc_fallback: assert property (st_q == LD_CRC && crc_rx_q != crc_q && prog_s
		|=> st_q == LD_FALL ##1 cfg_erase_o)
		else $error("bad row did not erase and fall back");
	a_pulse_timeout: assert property (attempting && pulse_q >= TOUT && prog_s |=> st_q == LD_FALL)
		else $error("timeout did not fall back");
	a_fail_event: assert property (st_q == LD_FALL && (attempt_q || !dual_run_q) && prog_s
		&& !eng_busy && !eng_start_q |=> load_fail_o && failed_q && !user_mode_o)
		else $error("double failure not reported");
	a_preamble_bound: assert property (st_q == LD_PRE |-> pre_cnt_q <= PLIM)
		else $error("preamble search overran");
	a_dual_base: assert property (st_q == LD_ARB && ctrl_q[`LD_CTRL_DUAL] |=> base_q == `LD_DUAL_BASE)
		else $error("dual image base wrong");
	a_single_base: assert property (st_q == LD_ARB && !ctrl_q[`LD_CTRL_DUAL] |=> base_q == 24'h0)
		else $error("single image base wrong");

	c_user_mode: cover property ($rose(user_mode_o));
	c_fallback: cover property (st_q == LD_FALL && !attempt_q && dual_run_q);
	c_load_fail: cover property (load_fail_o);
	c_row_written: cover property (cfg_row_end_o);

endmodule

`default_nettype wire

// File: test/ld_flash_model.sv
/*
 behavioural serial flash: mode 0, msb first, answers the plain read command.
 assumes the bench resolves the pins and fills mem before each load.
*/
`timescale 1ns/1ps
`default_nettype none

module ld_flash_model (
	// serial pins
	input wire logic sclk_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	output logic miso_o
);
	logic [7:0] mem [0:63];
	logic [31:0] hdr = '0;
	int nbit = 0;
	initial miso_o = 1'b0;
	////////////////////////////////////////////////
	always @(negedge sel_n_i) nbit = 0;
	always @(posedge sclk_i) begin
		if (!sel_n_i) begin
			if (nbit < 32) hdr = {hdr[30:0], mosi_i};
			nbit = nbit + 1;
		end
	end
	////////////////////////////////////////////////
	// released line shows the inverse level, so a stale bit is never read as good
	always @(negedge sclk_i or posedge sel_n_i) begin
		if (sel_n_i) miso_o = ~miso_o;
		else if (nbit >= 32 && hdr[31:24] == 8'h03)
			miso_o = mem[6'((nbit - 32) / 8)][3'(7 - (nbit - 32) % 8)];
	end
endmodule
`default_nettype wire

// File: test/test_spi_master_boot_loader.sv
/*
 bench for the serial flash boot loader: table of boot cases, then hand tests.
 assumes the flash model and the loader sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ld_cfg.svh"

module test_spi_master_boot_loader import ld_pkg::*;;
	localparam int RB = 4;
	localparam int NR = 2;
	localparam int NW = RB * NR;
	localparam logic [7:0] RATE = 8'h08;
	typedef struct packed {
		logic [5:0] ctrl;
		logic [1:0] kind;
		logic sdm_ok;
		logic hold;
		logic fre;
		logic sel;
		logic [23:0] addr;
		logic user;
		logic [1:0] ner;
	} ld_row_t;
	ld_row_t rows [9] = '{
		'{6'h04, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 24'h000000, 1'b1, 2'h0},
		'{6'h05, 2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 24'h010000, 1'b1, 2'h1},
		'{6'h05, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1, 24'h010000, 1'b0, 2'h2},
		'{6'h07, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 24'h000000, 1'b1, 2'h0},
		'{6'h07, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 24'h010000, 1'b1, 2'h1},
		'{6'h05, 2'h0, 1'b1, 1'b1, 1'b0, 1'b1, 24'h010000, 1'b1, 2'h1},
		'{6'h09, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 24'h000000, 1'b1, 2'h0},
		'{6'h04, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 24'h000000, 1'b1, 2'h0},
		'{6'h04, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 24'h000000, 1'b0, 2'h1}
	};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	ld_bus_t bus = '0;
	logic [31:0] rdata;
	ld_pins_t pins;
	ld_pins_t pins_oe;
	logic miso;
	logic prog_n = 1'b1;
	logic fre = 1'b0;
	logic sdm_start;
	logic sdm_done = 1'b0;
	logic sdm_fail = 1'b0;
	logic [7:0] cfg_data;
	logic cfg_wr;
	logic row_end;
	logic erase;
	logic cfg_done = 1'b0;
	logic user_mode;
	logic load_fail;
	ld_scan_t scan = '0;
	logic scan_miso;
	logic clr = 1'b0;
	logic sdm_ok = 1'b1;
	logic hold = 1'b0;
	logic sel_seen = 1'b0;
	logic fail_seen = 1'b0;
	logic [31:0] v;
	int nwr = 0;
	int ner = 0;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	wire logic sclk = pins_oe.clk ? pins.clk : 1'b1;
	wire logic sel_n = pins_oe.sel_n ? pins.sel_n : 1'b1;
	wire logic mosi = pins_oe.mosi ? pins.mosi : 1'b1;

	always #2 clk = ~clk;

	ld_boot_loader #(.ROW_BYTES(RB), .ROWS(NR), .PRE_LIMIT(8), .TIMEOUT_PULSES(300),
		.PREAMBLE(16'ha5c3)) dut (
		.ref_clk_i(clk), .resetn_i(resetn), .bus_i(bus), .rdata_o(rdata),
		.flash_o(pins), .flash_oe_o(pins_oe), .master_serial_in_i(miso),
		.program_request_n_i(prog_n), .scan_i(scan), .scan_miso_o(scan_miso),
		.feature_row_erased_i(fre), .sdm_start_o(sdm_start), .sdm_done_i(sdm_done),
		.sdm_fail_i(sdm_fail), .cfg_data_o(cfg_data), .cfg_wr_o(cfg_wr),
		.cfg_row_end_o(row_end), .cfg_erase_o(erase), .cfg_done_i(cfg_done),
		.user_mode_o(user_mode), .load_fail_o(load_fail));
	ld_flash_model flash (.sclk_i(sclk), .sel_n_i(sel_n), .mosi_i(mosi), .miso_o(miso));
	////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			c = (c[15] ^ b[i]) ? {c[14:0], 1'b0} ^ `LD_CRC_POLY : {c[14:0], 1'b0};
		return c;
	endfunction
	// image: two pad bytes, preamble, rate byte, rows with crc; kind 1 spoils crc
	task automatic build(input logic [1:0] kind);
		logic [15:0] c;
		for (int i = 0; i < 64; i++) flash.mem[i] = 8'hff;
		if (kind != 2'h2) begin
			flash.mem[2] = 8'ha5;
			flash.mem[3] = 8'hc3;
			flash.mem[4] = RATE;
			for (int r = 0; r < NR; r++) begin
				c = `LD_CRC_INIT;
				for (int j = 0; j < RB; j++) begin
					flash.mem[5 + r * (RB + 2) + j] = 8'h31 + 8'(r * RB + j);
					c = crc(c, 8'h31 + 8'(r * RB + j));
				end
				if (kind == 2'h1) c = ~c;
				flash.mem[5 + r * (RB + 2) + RB] = c[15:8];
				flash.mem[6 + r * (RB + 2) + RB] = c[7:0];
			end
		end
	endtask
	task automatic wait_end();
		repeat (8) @(posedge clk);
		for (int k = 0; k < 40000 && user_mode !== 1'b1 && fail_seen !== 1'b1; k++)
			@(posedge clk);
		repeat (8) @(posedge clk);
	endtask
	////////////////////////////////////////////////
	always @(posedge clk) begin
		if (clr) begin
			sel_seen <= 1'b0;
			fail_seen <= 1'b0;
			nwr <= 0;
			ner <= 0;
			cfg_done <= 1'b0;
		end else begin
			if (!sel_n) sel_seen <= 1'b1;
			if (erase) ner <= ner + 1;
			if (load_fail) fail_seen <= 1'b1;
			if (cfg_wr) begin
				chk(32'(cfg_data), 32'(8'h31 + 8'(nwr)));
				chk(32'(row_end), 32'((nwr % RB) == RB - 1));
				nwr <= nwr + 1;
			end
			if (sdm_done || (!hold && nwr == NW)) cfg_done <= 1'b1;
		end
	end
	always @(posedge clk) begin
		if (sdm_start) begin
			repeat (4) @(posedge clk);
			sdm_done <= sdm_ok;
			sdm_fail <= !sdm_ok;
			@(posedge clk);
			sdm_done <= 1'b0;
			sdm_fail <= 1'b0;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_fail++;
			close_out();
		end
	end
	////////////////////////////////////////////////
	initial begin
		build(2'h0);
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			if (i > 0) begin
				build(rows[i].kind);
				sdm_ok <= rows[i].sdm_ok;
				hold <= rows[i].hold;
				fre <= rows[i].fre;
				clr <= 1'b1;
				wr(`LD_OFF_CTRL, 32'(rows[i].ctrl));
				clr <= 1'b0;
				wr(`LD_OFF_CMD, 32'h1);
			end
			wait_end();
			chk(32'(user_mode), 32'(rows[i].user));
			chk(32'(fail_seen), 32'(!rows[i].user));
			chk(32'(sel_seen), 32'(rows[i].sel));
			chk(32'(ner), 32'(rows[i].ner));
			chk(32'(nwr), 32'((rows[i].sel && rows[i].kind == 2'h0) ? NW : 0));
			chk(32'(pins_oe), 32'h0);
			if (rows[i].sel) begin
				chk(32'(flash.hdr[31:24]), 32'(`LD_READ_OP));
				chk(32'(flash.hdr[23:0]), 32'(rows[i].addr));
			end
		end
		rd(8'h40, v);
		chk(v, 32'h0);
		build(2'h0);
		clr <= 1'b1;
		prog_n <= 1'b0;
		@(posedge clk);
		clr <= 1'b0;
		repeat (20) @(posedge clk);
		prog_n <= 1'b1;
		repeat (100) @(posedge clk);
		rd(`LD_OFF_STATUS, v);
		chk(32'(v[15:8]), 32'(`LD_NOM_HALF));
		chk(32'(v[2]), 32'h1);
		wait_end();
		chk(32'(user_mode), 32'h1);
		chk(32'(pins_oe), 32'h0);
		rd(`LD_OFF_STATUS, v);
		chk(32'(v[15:8]), 32'(RATE));
		wr(`LD_OFF_CTRL, 32'h34);
		wr(`LD_OFF_UTX, 32'ha5);
		repeat (8) @(posedge clk);
		chk(32'(pins_oe), 32'h7);
		chk(32'(pins.sel_n), 32'h0);
		repeat (160) @(posedge clk);
		rd(`LD_OFF_STATUS, v);
		chk(32'(v[5]), 32'h0);
		chk(32'(flash.hdr[7:0]), 32'ha5);
		scan <= '{1'b1, 1'b1, 1'b1, 1'b0};
		repeat (12) @(posedge clk);
		chk(32'(pins), 32'h6);
		chk(32'(pins_oe), 32'h7);
		chk(32'(scan_miso), 32'(miso));
		close_out();
	end
endmodule
`default_nettype wire
